/* File: common/nvb_regs.svh */
// Register offsets, bit positions and timing figures of the byte access unit
`ifndef NVB_REGS_SVH
`define NVB_REGS_SVH

`define NVB_OFS_CONTROL 6'h1C
`define NVB_OFS_DATA 6'h1D
`define NVB_OFS_ADDR_LOW 6'h1E
`define NVB_OFS_ADDR_HIGH 6'h1F

`define NVB_CTL_READ 0
`define NVB_CTL_WRITE 1
`define NVB_CTL_MWE 2

`define NVB_ADDR_BITS 9
`define NVB_DEPTH 512
`define NVB_LOW_BITS 8
`define NVB_DATA_RESET 8'h00

`define NVB_MWE_WINDOW 3'h4
`define NVB_READ_STALL 3'h4
`define NVB_WRITE_STALL 3'h2

`define NVB_WRITE_OSC_CYCLES 8448
`define NVB_OSC_PERIOD_NS 1000
`define NVB_CLK_PERIOD_NS 10

`endif

/* File: common/nvb_pkg.sv */
// Types shared by the byte access unit and its bench
package nvb_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } nvb_io_req_t;

  typedef enum logic [1:0] {
    NVB_IDLE = 2'b01,
    NVB_PROG = 2'b10
  } nvb_state_t;

endpackage

/* File: verilog/nvb_eeprom_access.sv */
// Byte access unit for the 512-byte nonvolatile data store

`include "nvb_regs.svh"

module nvb_eeprom_access
  import nvb_pkg::*;
#(
  parameter int WRITE_CYCLES =
    `NVB_WRITE_OSC_CYCLES * (`NVB_OSC_PERIOD_NS / `NVB_CLK_PERIOD_NS)
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire nvb_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic cpu_stall
);

  localparam int AW = `NVB_ADDR_BITS;
  localparam int HW = AW - `NVB_LOW_BITS;
  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam logic [CW-1:0] LAST_CNT = CW'(WRITE_CYCLES - 1);

  function automatic logic io_hit(input logic [5:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  // Store array; never reset, contents are nonvolatile by intent
  logic [7:0] store_mem [`NVB_DEPTH];

  logic [AW-1:0] nv_address_r;
  logic [7:0] nv_data_byte_r;
  logic [2:0] mwe_cnt_r;
  logic [2:0] stall_cnt_r;
  logic [CW-1:0] busy_cnt_r;
  logic [AW-1:0] prog_addr_r;
  logic [7:0] prog_data_r;
  logic [7:0] io_rdata_r;
  nvb_state_t state_r;
  nvb_state_t state_nxt;

  // Decode of the core's I/O cycle
  wire wr_ctl = io_req.wr && io_hit(io_req.addr, `NVB_OFS_CONTROL);
  wire wr_data = io_req.wr && io_hit(io_req.addr, `NVB_OFS_DATA);
  wire wr_low = io_req.wr && io_hit(io_req.addr, `NVB_OFS_ADDR_LOW);
  wire wr_high = io_req.wr && io_hit(io_req.addr, `NVB_OFS_ADDR_HIGH);

  wire busy = (state_r == NVB_PROG);
  wire mwe_on = (mwe_cnt_r != 3'h0);
  wire mwe_set = wr_ctl && io_req.wdata[`NVB_CTL_MWE];

  // Reads are dropped silently while a write runs
  wire read_strobe = wr_ctl && io_req.wdata[`NVB_CTL_READ];
  wire rd_go = read_strobe && !busy;
  // Strobe only counts inside the master enable window
  wire wr_go = wr_ctl && io_req.wdata[`NVB_CTL_WRITE] && mwe_on && !busy;
  wire prog_done = busy && (busy_cnt_r == '0);
  wire [7:0] mem_rd = store_mem[nv_address_r];

  wire [7:0] ctl_view = {
    5'h00,
    mwe_on,
    busy,
    1'b0
  };
  wire [7:0] addr_high_view = {{(8 - HW){1'b0}}, nv_address_r[AW-1:`NVB_LOW_BITS]};
  wire [7:0] rd_mux =
    io_hit(io_req.addr, `NVB_OFS_CONTROL) ? ctl_view :
    io_hit(io_req.addr, `NVB_OFS_DATA) ? nv_data_byte_r :
    io_hit(io_req.addr, `NVB_OFS_ADDR_LOW) ? nv_address_r[`NVB_LOW_BITS-1:0] :
    io_hit(io_req.addr, `NVB_OFS_ADDR_HIGH) ? addr_high_view :
    8'h00;

  assign io_rdata = io_rdata_r;
  assign cpu_stall = (stall_cnt_r != 3'h0);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      NVB_IDLE: begin
        if (wr_go) begin
          state_nxt = NVB_PROG;
        end
      end
      NVB_PROG: begin
        if (prog_done) begin
          state_nxt = NVB_IDLE;
        end
      end
      default: state_nxt = NVB_IDLE;
    endcase
  end

  // Address has no reset so that it powers up undefined
  always_ff @(posedge ref_clk) begin
    if (wr_low && !busy) begin
      nv_address_r[`NVB_LOW_BITS-1:0] <= io_req.wdata;
    end
    if (wr_high && !busy) begin
      nv_address_r[AW-1:`NVB_LOW_BITS] <= io_req.wdata[HW-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_data_byte_r <= `NVB_DATA_RESET;
    end else if (rd_go) begin
      nv_data_byte_r <= mem_rd;
    end else if (wr_data) begin
      nv_data_byte_r <= io_req.wdata;
    end
  end

  // A fresh set restarts the window and wins over the countdown
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mwe_cnt_r <= 3'h0;
    end else if (mwe_set) begin
      mwe_cnt_r <= `NVB_MWE_WINDOW;
    end else if (mwe_on) begin
      mwe_cnt_r <= mwe_cnt_r - 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_cnt_r <= 3'h0;
    end else if (rd_go) begin
      stall_cnt_r <= `NVB_READ_STALL;
    end else if (wr_go) begin
      stall_cnt_r <= `NVB_WRITE_STALL;
    end else if (cpu_stall) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end
  end

  // Address and data are latched at launch, so later data writes cannot corrupt it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= NVB_IDLE;
      busy_cnt_r <= '0;
      prog_addr_r <= '0;
      prog_data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (wr_go) begin
        busy_cnt_r <= LAST_CNT;
        prog_addr_r <= nv_address_r;
        prog_data_r <= nv_data_byte_r;
      end else if (busy && !prog_done) begin
        busy_cnt_r <= busy_cnt_r - CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (prog_done) begin
      store_mem[prog_addr_r] <= prog_data_r;
    end
  end

  // Read strobe is never stored, so it always reads back as zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata_r <= 8'h00;
    end else if (io_req.rd) begin
      io_rdata_r <= rd_mux;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_read_stall;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence

  sequence s_write_stall;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence

  property p_read_stall;
    rd_go |=> s_read_stall;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall length wrong");

  property p_write_stall;
    wr_go |=> s_write_stall;
  endproperty
  a_write_stall: assert property (p_write_stall) else $error("write stall length wrong");

  sequence s_mwe_quiet;
    mwe_set ##1 (!mwe_set) [*4];
  endsequence

  property p_mwe_timeout;
    s_mwe_quiet |=> !mwe_on && !wr_go;
  endproperty
  a_mwe_timeout: assert property (p_mwe_timeout) else $error("master enable outlived window");

  property p_no_mwe_no_write;
    (wr_ctl && io_req.wdata[`NVB_CTL_WRITE] && !mwe_on && !busy) |=> !busy;
  endproperty
  a_no_mwe_no_write: assert property (p_no_mwe_no_write) else $error("write without enable");

  property p_read_data;
    rd_go |=> nv_data_byte_r == $past(mem_rd);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not loaded");

  property p_addr_hold;
    busy && (wr_low || wr_high) |=> nv_address_r == $past(nv_address_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed while busy");

  property p_busy_end;
    busy && (busy_cnt_r == '0) |=> !busy && $fell(busy);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("write strobe did not clear");

  property p_busy_start;
    wr_go |=> busy && (busy_cnt_r == LAST_CNT);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("write timer not loaded");

  property p_commit;
    prog_done |=> store_mem[$past(prog_addr_r)] == $past(prog_data_r);
  endproperty
  a_commit: assert property (p_commit) else $error("byte not programmed");

  property p_high_zero;
    io_req.rd && io_hit(io_req.addr, `NVB_OFS_ADDR_HIGH) |=> io_rdata[7:HW] == '0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("reserved address bits nonzero");

  property p_no_read_busy;
    busy && wr_ctl |=> !$changed(nv_data_byte_r) || $past(wr_data);
  endproperty
  a_no_read_busy: assert property (p_no_read_busy) else $error("read during write");

  property p_data_load;
    wr_data |=> nv_data_byte_r == $past(io_req.wdata);
  endproperty
  a_data_load: assert property (p_data_load) else $error("data byte not written");

  property p_addr_low_load;
    wr_low && !busy |=> nv_address_r[`NVB_LOW_BITS-1:0] == $past(io_req.wdata);
  endproperty
  a_addr_low_load: assert property (p_addr_low_load) else $error("low address not loaded");

  property p_addr_high_load;
    wr_high && !busy |=> nv_address_r[AW-1:`NVB_LOW_BITS] == $past(io_req.wdata[HW-1:0]);
  endproperty
  a_addr_high_load: assert property (p_addr_high_load) else $error("high address not loaded");

  property p_prog_capture;
    wr_go |=> prog_addr_r == $past(nv_address_r) && prog_data_r == $past(nv_data_byte_r);
  endproperty
  a_prog_capture: assert property (p_prog_capture) else $error("launch capture wrong");

  property p_busy_count;
    busy && !prog_done |=> busy && (busy_cnt_r == $past(busy_cnt_r) - CW'(1));
  endproperty
  a_busy_count: assert property (p_busy_count) else $error("write timer skipped");

  property p_strobe_clear;
    io_req.rd && io_hit(io_req.addr, `NVB_OFS_CONTROL) |=> io_rdata[0] == 1'b0 && io_rdata[7:3] == 5'h00;
  endproperty
  a_strobe_clear: assert property (p_strobe_clear) else $error("read strobe reads back set");

  property p_ctl_busy_view;
    io_req.rd && io_hit(io_req.addr, `NVB_OFS_CONTROL) |=> io_rdata[1] == $past(busy);
  endproperty
  a_ctl_busy_view: assert property (p_ctl_busy_view) else $error("busy not visible");

  property p_unmapped_zero;
    io_req.rd && (io_req.addr < `NVB_OFS_CONTROL) |=> io_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  property p_no_stray_stall;
    !cpu_stall && !rd_go && !wr_go |=> !cpu_stall;
  endproperty
  a_no_stray_stall: assert property (p_no_stray_stall) else $error("stall without access");

  // A fresh set only lengthens the window, so four open cycles always follow
  sequence s_mwe_open;
    mwe_on [*4];
  endsequence

  property p_mwe_window;
    mwe_set |=> s_mwe_open;
  endproperty
  a_mwe_window: assert property (p_mwe_window) else $error("master enable window short");

endmodule

/* File: bench/nvb_core_model.sv */
// Core-side model that presents I/O requests to the byte access unit
module nvb_core_model
  import nvb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire nvb_io_req_t cmd,
  input wire logic cpu_stall,
  output nvb_io_req_t io_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // A halted core issues nothing; idle address and data toggle so stale values never match
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_req <= '0;
    end else if (!cpu_stall && (cmd.wr || cmd.rd)) begin
      io_req <= cmd;
    end else begin
      io_req <= {2'b00, ~io_req.addr, ~io_req.wdata};
    end
  end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the byte access unit
`include "nvb_regs.svh"
module testbench;
  import nvb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  nvb_io_req_t cmd = '0;
  nvb_io_req_t io_req;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic [7:0] mem_exp [512];
  logic [7:0] q;
  logic [8:0] a;
  int n, polls, mismatches, cmp_count;
  always #5 ref_clk = ~ref_clk;
  nvb_eeprom_access #(.WRITE_CYCLES(WC)) u_nvb_eeprom_access (.ref_clk(ref_clk),
    .reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata), .cpu_stall(cpu_stall));
  nvb_core_model u_nvb_core_model (.ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd),
    .cpu_stall(cpu_stall), .io_req(io_req));
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [7:0] hi_exp(logic [7:0] v);
    return {7'h00, v[0]};
  endfunction
  // Polls start five cycles after the strobe and repeat every three
  function automatic int poll_exp();
    return (WC - 5) / 3 + 1;
  endfunction
  // One request; q gets read data, n the cycles the core stayed halted
  task automatic op(logic wr, logic [5:0] ad, logic [7:0] d);
    @(posedge ref_clk) cmd <= '{wr: wr, rd: ~wr, addr: ad, wdata: d};
    @(posedge ref_clk) cmd <= '0;
    @(posedge ref_clk) #1 q = io_rdata;
    for (n = 0; cpu_stall === 1'b1 && n < 20; n++) @(posedge ref_clk) #1;
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic set_addr(logic [8:0] ad);
    op(1'b1, `NVB_OFS_ADDR_HIGH, {7'h00, ad[8]});
    op(1'b1, `NVB_OFS_ADDR_LOW, ad[7:0]);
  endtask
  task automatic nv_write(logic [8:0] ad, logic [7:0] d);
    set_addr(ad);
    op(1'b1, `NVB_OFS_DATA, d);
    op(1'b1, `NVB_OFS_CONTROL, 8'h04);
    op(1'b1, `NVB_OFS_CONTROL, 8'h02);
    check("write stall", 8'(n), 8'h02);
    mem_exp[ad] = d;
  endtask
  task automatic wait_idle();
    op(1'b0, `NVB_OFS_CONTROL, 8'h00);
    check("busy", q & 8'h02, 8'h02);
    for (polls = 0; q[1] !== 1'b0; polls++) begin
      if (polls > 30) begin
        mismatches++;
        tally_and_finish();
      end
      op(1'b0, `NVB_OFS_CONTROL, 8'h00);
    end
  endtask
  task automatic nv_read(logic [8:0] ad);
    set_addr(ad);
    op(1'b1, `NVB_OFS_CONTROL, 8'h01);
    check("read stall", 8'(n), 8'h04);
    op(1'b0, `NVB_OFS_CONTROL, 8'h00);
    check("read strobe", q, 8'h00);
    op(1'b0, `NVB_OFS_DATA, 8'h00);
    check("read byte", q, mem_exp[ad]);
  endtask
  initial begin
    n = $urandom(32'h4B3F);
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    check("reset rdata", io_rdata, 8'h00);
    op(1'b0, `NVB_OFS_DATA, 8'h00);
    check("data reset", q, `NVB_DATA_RESET);
    op(1'b0, `NVB_OFS_CONTROL, 8'h00);
    check("control reset", q, 8'h00);
    op(1'b0, 6'h00, 8'h00);
    check("unmapped", q, 8'h00);
    op(1'b1, `NVB_OFS_ADDR_HIGH, 8'hFF);
    op(1'b0, `NVB_OFS_ADDR_HIGH, 8'h00);
    check("address high", q, hi_exp(8'hFF));
    for (int i = 0; i < 4; i++) begin
      a = 9'($urandom);
      op(1'b1, `NVB_OFS_DATA, a[7:0]);
      op(1'b0, `NVB_OFS_DATA, 8'h00);
      check("data reg", q, a[7:0]);
    end
    // Both ends of the address range first, then random bytes
    for (int i = 0; i < 6; i++) begin
      a = i == 0 ? 9'h000 : i == 1 ? 9'h1FF : 9'($urandom);
      nv_write(a, 8'($urandom));
      wait_idle();
      check("write time", 8'(polls), 8'(poll_exp()));
      nv_read(a);
    end
    op(1'b1, `NVB_OFS_DATA, ~mem_exp[a]);
    op(1'b1, `NVB_OFS_CONTROL, 8'h02);
    op(1'b0, `NVB_OFS_CONTROL, 8'h00);
    check("no enable", q, 8'h00);
    op(1'b1, `NVB_OFS_CONTROL, 8'h04);
    op(1'b0, `NVB_OFS_CONTROL, 8'h00);
    check("enable open", q, 8'h04);
    op(1'b1, `NVB_OFS_CONTROL, 8'h02);
    op(1'b0, `NVB_OFS_CONTROL, 8'h00);
    check("enable expired", q, 8'h00);
    nv_read(a);
    nv_write(9'h0A5, 8'h3C);
    op(1'b1, `NVB_OFS_ADDR_LOW, 8'h5A);
    op(1'b1, `NVB_OFS_CONTROL, 8'h01);
    check("busy read stall", 8'(n), 8'h00);
    wait_idle();
    op(1'b0, `NVB_OFS_ADDR_LOW, 8'h00);
    check("address kept", q, 8'hA5);
    nv_read(9'h0A5);
    tally_and_finish();
  end
endmodule
